/* File: rtl/dcf_regs.svh */
// Constants for the programmable-flag FIFO: widths, depths and default offsets.
// Included by the FIFO design file only; the package does not include it.
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define DCF_DATA_W      18
`define DCF_OFS_W       12
`define DCF_OFS_LSB     0
`define DCF_STAGE_DEPTH 16

// ----------------------------------------------------------------------------
// Default offsets per depth
// ----------------------------------------------------------------------------
`define DCF_OFS_DEF_256  12'h01f
`define DCF_OFS_DEF_512  12'h03f
`define DCF_OFS_DEF_1K   12'h07f
`define DCF_OFS_DEF_4K   12'h07f
`define DCF_DEPTH_DEF    1024

`endif

/* File: rtl/dcf_pkg.sv */
// Types shared by the programmable-flag FIFO.
// Assumes dcf_regs.svh sits beside it.
`default_nettype none
package dcf_pkg;
  // Which offset register the next load access targets
  typedef enum logic {OFS_EMPTY, OFS_FULL} dcf_ofs_sel_t;
endpackage
`default_nettype wire

/* File: rtl/dcf_fifo.sv */
// Programmable-flag FIFO of 18-bit words with a 16-word input stage.
// Assumes one clock, synchronous pins, and reset_i held long enough to settle.
`include "dcf_regs.svh"
`default_nettype none

// ----------------------------------------------------------------------------
// Input stage FIFO
// ----------------------------------------------------------------------------
module dcf_stage_fifo #(
  parameter int W = `DCF_DATA_W,
  parameter int D = `DCF_STAGE_DEPTH
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // Honest flags straight from the occupancy count
  assign in_ready_o  = (cnt_q != D[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage writes
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // dcf_stage_fifo

// ----------------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------------
module dcf_fifo #(
  parameter int DEPTH = `DCF_DEPTH_DEF
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   write_en_n_i,
  input  wire logic                   read_en_n_i,
  input  wire logic                   threshold_load_n_i,
  input  wire logic                   output_enable_n_i,
  input  wire logic                   read_permission_i,
  input  wire logic                   sync_flag_mode_n_i,
  input  wire logic                   retransmit_pulse_i,
  input  wire logic [`DCF_DATA_W-1:0] write_data_i,
  output logic      [`DCF_DATA_W-1:0] read_data_o,
  output logic                        read_data_oe_n_o,
  output logic                        write_ready_o,
  output logic                        empty_flag_n_o,
  output logic                        full_flag_n_o,
  output logic                        almost_empty_flag_n_o,
  output logic                        almost_full_flag_n_o,
  output logic                        half_full_flag_n_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = DEPTH[AW:0];
  localparam logic [AW:0] HALF_C  = DEPTH_C >> 1;
  localparam logic [`DCF_OFS_W-1:0] OFS_DEF =
    (DEPTH == 256) ? `DCF_OFS_DEF_256 :
    (DEPTH == 512) ? `DCF_OFS_DEF_512 :
    (DEPTH == 1024) ? `DCF_OFS_DEF_1K : `DCF_OFS_DEF_4K;

  logic [`DCF_DATA_W-1:0] mem_q [DEPTH];
  logic [AW-1:0]          wp_q;
  logic [AW-1:0]          rp_q;
  logic [AW:0]            cnt_q;
  logic [AW:0]            cnt_d;
  logic [AW:0]            wr_total_q;
  logic [`DCF_DATA_W-1:0] rdata_q;
  logic [`DCF_OFS_W-1:0]  ae_dist_q;
  logic [`DCF_OFS_W-1:0]  af_dist_q;
  dcf_pkg::dcf_ofs_sel_t  wsel_q;
  dcf_pkg::dcf_ofs_sel_t  rsel_q;
  logic                   ef_n_q;
  logic                   ff_n_q;
  logic                   ae_n_q;
  logic                   af_n_q;
  logic                   hf_n_q;
  logic                   ae_n_c;
  logic                   af_n_c;
  logic                   stg_in_valid;
  logic                   stg_valid;
  logic [`DCF_DATA_W-1:0] stg_data;
  logic                   do_wr;
  logic                   do_rd;
  logic                   prog_wr;
  logic                   prog_rd;

  // --------------------------------------------------------------------------
  // Write side: staging FIFO feeds the main array
  // --------------------------------------------------------------------------
  // Write accepted only with load high and the full flag high
  assign stg_in_valid = ~write_en_n_i & threshold_load_n_i & ff_n_q;
  // Array refuses words at full depth; stage words wait there, and the full flag gate drops new writes
  assign do_wr   = stg_valid & (cnt_q != DEPTH_C);
  assign prog_wr = ~write_en_n_i & ~threshold_load_n_i;
  assign prog_rd = ~read_en_n_i & ~threshold_load_n_i;
  // Retransmit wins over a read in the same cycle
  assign do_rd   = ~read_en_n_i & threshold_load_n_i & ef_n_q & (cnt_q != '0)
                   & ~retransmit_pulse_i;

  dcf_stage_fifo #(
    .W (`DCF_DATA_W),
    .D (`DCF_STAGE_DEPTH)
  ) u_stage (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (stg_in_valid),
    .in_ready_o  (write_ready_o),
    .in_data_i   (write_data_i),
    .out_valid_o (stg_valid),
    .out_ready_i (cnt_q != DEPTH_C),
    .out_data_o  (stg_data)
  );

  // Main array write
  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem_q[wp_q] <= stg_data;
    end
  end

  // --------------------------------------------------------------------------
  // Pointers and occupancy
  // --------------------------------------------------------------------------
  // Next count; retransmit recounts from writes since reset
  always_comb begin
    if (retransmit_pulse_i) begin
      cnt_d = wr_total_q + {{AW{1'b0}}, do_wr};
    end else begin
      cnt_d = cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_q       <= '0;
      rp_q       <= '0;
      cnt_q      <= '0;
      wr_total_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (do_wr) begin
        wp_q <= wp_q + 1'b1;
      end
      // Saturates: replay beyond one depth of writes is undefined anyway
      if (do_wr && wr_total_q != DEPTH_C) begin
        wr_total_q <= wr_total_q + 1'b1;
      end
      if (retransmit_pulse_i) begin
        rp_q <= '0;
      end else if (do_rd) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Offset registers and their alternation
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ae_dist_q <= OFS_DEF;
      af_dist_q <= OFS_DEF;
      wsel_q    <= dcf_pkg::OFS_EMPTY;
    end else if (prog_wr) begin
      // Position kept across load going high
      unique case (wsel_q)
        dcf_pkg::OFS_EMPTY: begin
          ae_dist_q <= write_data_i[`DCF_OFS_LSB +: `DCF_OFS_W];
          wsel_q    <= dcf_pkg::OFS_FULL;
        end
        dcf_pkg::OFS_FULL: begin
          af_dist_q <= write_data_i[`DCF_OFS_LSB +: `DCF_OFS_W];
          wsel_q    <= dcf_pkg::OFS_EMPTY;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Output register
  // --------------------------------------------------------------------------
  // Holds the last valid word while empty; reads of offsets zero-extend
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_q <= '0;
      rsel_q  <= dcf_pkg::OFS_EMPTY;
    end else if (prog_rd) begin
      rsel_q  <= (rsel_q == dcf_pkg::OFS_EMPTY) ? dcf_pkg::OFS_FULL : dcf_pkg::OFS_EMPTY;
      rdata_q <= {{(`DCF_DATA_W - `DCF_OFS_W){1'b0}},
                  (rsel_q == dcf_pkg::OFS_EMPTY) ? ae_dist_q : af_dist_q};
    end else if (do_rd) begin
      rdata_q <= mem_q[rp_q];
    end
  end

  assign read_data_o      = rdata_q;
  assign read_data_oe_n_o = output_enable_n_i | ~read_permission_i;

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  // Combinational almost flags for the asynchronous mode
  // Full offset width kept: an offset above the depth must not wrap
  assign ae_n_c = ~(13'(cnt_q) <= 13'(ae_dist_q));
  assign af_n_c = ~(13'(cnt_q) + 13'(af_dist_q) >= 13'(DEPTH_C));

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ef_n_q <= 1'b0;
      ff_n_q <= 1'b1;
      ae_n_q <= 1'b0;
      af_n_q <= 1'b1;
      hf_n_q <= 1'b1;
    end else begin
      ef_n_q <= (cnt_d != '0);
      ff_n_q <= (cnt_d != DEPTH_C);
      hf_n_q <= (cnt_d <= HALF_C);
      ae_n_q <= ~(13'(cnt_d) <= 13'(ae_dist_q));
      af_n_q <= ~(13'(cnt_d) + 13'(af_dist_q) >= 13'(DEPTH_C));
    end
  end

  assign empty_flag_n_o        = ef_n_q;
  assign full_flag_n_o         = ff_n_q;
  assign half_full_flag_n_o    = hf_n_q;
  assign almost_empty_flag_n_o = sync_flag_mode_n_i ? ae_n_c : ae_n_q;
  assign almost_full_flag_n_o  = sync_flag_mode_n_i ? af_n_c : af_n_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  full_blocks_write_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !ff_n_q |-> !stg_in_valid)
    else $error("write accepted while full flag low");

  empty_holds_data_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (!ef_n_q && threshold_load_n_i) |=> $stable(rdata_q))
    else $error("output changed while empty");

  read_advances_ptr_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    do_rd |=> (rp_q == $past(rp_q) + 1'b1))
    else $error("read did not advance read pointer");

  retransmit_rewind_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    retransmit_pulse_i |=> (rp_q == '0)
      && (cnt_q == $past(wr_total_q) + (AW+1)'($past(do_wr))))
    else $error("retransmit did not rewind");

  prog_alternates_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (prog_wr && wsel_q == dcf_pkg::OFS_EMPTY) |=>
      (ae_dist_q == $past(write_data_i[`DCF_OFS_W-1:0])) && wsel_q == dcf_pkg::OFS_FULL)
    else $error("offset programming out of order");

  half_flag_level_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (cnt_q > HALF_C) |-> !hf_n_q)
    else $error("half-full flag high above half depth");

  empty_flag_level_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    ef_n_q == (cnt_q != '0))
    else $error("empty flag disagrees with count");

  output_release_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (output_enable_n_i || !read_permission_i) |-> read_data_oe_n_o)
    else $error("outputs driven without permission");

  sync_almost_full_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !sync_flag_mode_n_i |-> (almost_full_flag_n_o ==
      !(13'(cnt_q) + 13'(af_dist_q) >= 13'(DEPTH_C)) || $changed(af_dist_q)))
    else $error("almost-full flag wrong");

  full_flag_level_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    ff_n_q == (cnt_q != DEPTH_C))
    else $error("full flag disagrees with count");

  empty_read_refused_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (!ef_n_q && !read_en_n_i && !retransmit_pulse_i) |=> (rp_q == $past(rp_q)))
    else $error("read pointer moved while empty");

  load_blocks_array_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !threshold_load_n_i |-> (!stg_in_valid && !do_rd))
    else $error("array accessed while load low");

  prog_full_slot_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (prog_wr && wsel_q == dcf_pkg::OFS_FULL) |=>
      (af_dist_q == $past(write_data_i[`DCF_OFS_W-1:0])) && wsel_q == dcf_pkg::OFS_EMPTY)
    else $error("full offset programming out of order");

  ofs_read_upper_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    prog_rd |=> (rdata_q[`DCF_DATA_W-1:`DCF_OFS_W] == '0) && (rsel_q != $past(rsel_q)))
    else $error("offset read wrong");

  async_almost_empty_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    sync_flag_mode_n_i |-> (almost_empty_flag_n_o == (13'(cnt_q) > 13'(ae_dist_q))))
    else $error("asynchronous almost-empty flag wrong");

  output_drive_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (!output_enable_n_i && read_permission_i) |-> !read_data_oe_n_o)
    else $error("outputs released while enabled");
endmodule // dcf_fifo
`default_nettype wire

/* File: tb/dcf_bus_model.sv */
// Reading host's view of the three-state output bus.
// Assumes a weak pull-down on the board, so a released bus reads low.
`default_nettype none
module dcf_bus_model (
  input  wire logic [17:0] read_data_i,
  input  wire logic        oe_n_i,
  output logic      [17:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Released bus falls to the pull-down level, never the last word
  assign bus_o = oe_n_i ? 18'h0 : read_data_i;
endmodule // dcf_bus_model
`default_nettype wire

/* File: tb/test_dual_clock_fifo_prog_flags.sv */
// Self-checking bench for the programmable-flag FIFO, built at depth 256.
// Assumes the design files and dcf_bus_model are compiled first.
`default_nettype none
module test_dual_clock_fifo_prog_flags;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DP = 256;
  logic        sys_clk_i, reset_i, wen_n, ren_n, ld_n, oe_n, perm, sync_flag_mode_n_n, rt;
  logic [17:0] wdata, rdata, bus, last;
  logic        oe_n_o, wrdy, ef_n, ff_n, ae_n, af_n, hf_n;
  int          mismatches, checks_done, eofs, fofs, n;
  logic [17:0] q[$];
  logic [17:0] h[$];

  dcf_fifo #(.DEPTH(DP)) dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .write_en_n_i(wen_n),
    .read_en_n_i(ren_n), .threshold_load_n_i(ld_n), .output_enable_n_i(oe_n),
    .read_permission_i(perm), .sync_flag_mode_n_i(sync_flag_mode_n_n),
    .retransmit_pulse_i(rt), .write_data_i(wdata), .read_data_o(rdata),
    .read_data_oe_n_o(oe_n_o), .write_ready_o(wrdy), .empty_flag_n_o(ef_n),
    .full_flag_n_o(ff_n), .almost_empty_flag_n_o(ae_n),
    .almost_full_flag_n_o(af_n), .half_full_flag_n_o(hf_n));
  dcf_bus_model host (.read_data_i(rdata), .oe_n_i(oe_n_o), .bus_o(bus));

  // --------------------------------------------------------------------------
  // Clock and shared tasks
  // --------------------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(string nm, logic [17:0] seen, logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Fixed idle time; the input stage drains one word a cycle
  task automatic settle();
    repeat (20) @(negedge sys_clk_i);
  endtask

  // Burst of k writes; only the first acc are accepted
  task automatic wrn(int k, int acc);
    for (int i = 0; i < k; i++) begin
      wdata = 18'($urandom);
      wen_n = 1'b0;
      if (i < acc) q.push_back(wdata);
      @(negedge sys_clk_i);
    end
    wen_n = 1'b1;
  endtask

  // Burst of k reads; an empty buffer keeps showing the last word
  task automatic rdn(int k);
    for (int i = 0; i < k; i++) begin
      ren_n = 1'b0;
      @(negedge sys_clk_i);
      if (q.size() > 0) last = q.pop_front();
      chk("read_data", bus, last);
    end
    ren_n = 1'b1;
    @(negedge sys_clk_i);
  endtask

  // Upper bits carry noise; only the low twelve may land
  task automatic ofs_wr(int v);
    ld_n  = 1'b0;
    wen_n = 1'b0;
    wdata = {6'($urandom), 12'(v)};
    @(negedge sys_clk_i);
    ld_n  = 1'b1;
    wen_n = 1'b1;
    @(negedge sys_clk_i);
  endtask

  task automatic ofs_rd();
    ld_n  = 1'b0;
    ren_n = 1'b0;
    @(negedge sys_clk_i);
    chk("empty_ofs", bus, 18'(eofs));
    @(negedge sys_clk_i);
    chk("full_ofs", bus, 18'(fofs));
    ld_n  = 1'b1;
    ren_n = 1'b1;
    @(negedge sys_clk_i);
  endtask

  // Stage words count only once the array has room
  task automatic flags();
    int c;
    c = (q.size() > DP) ? DP : q.size();
    chk("empty", 18'(ef_n), 18'(c != 0));
    chk("full", 18'(ff_n), 18'(c != DP));
    chk("almost_empty", 18'(ae_n), 18'(c > eofs));
    chk("almost_full", 18'(af_n), 18'(c < DP - fofs));
    chk("half_full", 18'(hf_n), 18'(c <= DP / 2));
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    {mismatches, checks_done} = '0;
    {reset_i, wen_n, ren_n, ld_n, perm} = 5'h1f;
    {oe_n, sync_flag_mode_n_n, rt, wdata, last} = '0;
    void'($urandom(34116));
    repeat (2) @(negedge sys_clk_i);
    reset_i = 1'b0;
    eofs = 31;
    fofs = 31;
    chk("reset_data", bus, 18'h0);
    flags();
    ofs_rd();
    eofs = $urandom_range(60, 1);
    fofs = $urandom_range(60, 1);
    ofs_wr(eofs);
    ofs_wr(fofs);
    ofs_rd();
    // Random bursts, flags checked with both flag modes
    repeat (6) begin
      sync_flag_mode_n_n = 1'($urandom);
      n = $urandom_range(90, 1);
      if (n > DP - q.size()) n = DP - q.size(); // Never past full depth
      wrn(n, n);
      settle();
      flags();
      rdn($urandom_range(q.size(), 0));
      settle();
      flags();
    end
    rdn(q.size());
    wrn(DP, DP);
    settle();
    flags();
    wrn(17, 0);
    settle();
    chk("write_ready", 18'(wrdy), 18'h1);
    flags();
    oe_n = 1'b1;
    @(negedge sys_clk_i);
    chk("oe_released", 18'(oe_n_o), 18'h1);
    oe_n = 1'b0;
    perm = 1'b0;
    @(negedge sys_clk_i);
    chk("oe_no_perm", 18'(oe_n_o), 18'h1);
    perm = 1'b1;
    @(negedge sys_clk_i);
    chk("oe_driven", 18'(oe_n_o), 18'h0);
    rdn(q.size() + 3);
    flags();
    // Fresh reset, then rewind after a partial read
    reset_i = 1'b1;
    @(negedge sys_clk_i);
    reset_i = 1'b0;
    q.delete();
    eofs = 31;
    fofs = 31;
    wrn(6, 6);
    h = q;
    settle();
    rdn(4);
    rt = 1'b1;
    @(negedge sys_clk_i);
    rt = 1'b0;
    q = h;
    settle();
    flags();
    rdn(6);
    print_verdict();
  end

  // Watchdog against a hung run
  initial begin
    #2_000_000;
    mismatches++;
    print_verdict();
  end
endmodule // test_dual_clock_fifo_prog_flags
`default_nettype wire
